// ==== cpsc_map.svh ====
`ifndef CPSC_MAP_SVH
`define CPSC_MAP_SVH

// Register offsets
`define CPSC_OFF_PAGE       8'h00
`define CPSC_OFF_DSP_CTRL   8'h03
`define CPSC_OFF_CLK_ROLE   8'h0D
`define CPSC_OFF_STATUS_ONE 8'h7A
`define CPSC_OFF_CHECKSUM   8'h7E

// Page holding the serial-port and dsp controls
`define CPSC_PAGE_CFG       8'h01

// Reset values
`define CPSC_RST_PAGE       8'h00
`define CPSC_RST_DSP_CTRL   8'h00
`define CPSC_RST_CLK_ROLE   8'h00
`define CPSC_RST_CHECKSUM   8'h00

// Writable-bit masks, reserved bits stay at reset value
`define CPSC_WMASK_DSP_CTRL 8'h03
`define CPSC_WMASK_CLK_ROLE 8'hC6

// Field positions
`define CPSC_BIT_BIQUAD     0
`define CPSC_BIT_VOL_LOCK   1
`define CPSC_BIT_SEC_FS     1
`define CPSC_BIT_PRI_FS     2
`define CPSC_BIT_SEC_OVR    6
`define CPSC_BIT_PRI_OVR    7
`define CPSC_BIT_ALL_FLT    0
`define CPSC_BIT_SOME_FLT   1
`define CPSC_BIT_BOOST      2

`endif

// ==== cpsc_pkg.sv ====
package cpsc_pkg;

    // One register access from the control bus
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cpsc_req_t;

    // Resolved serial port clock roles
    typedef struct packed {
        logic bclk_out;
        logic frame_sync_out;
        logic auto_detect_en;
        logic use_int_frame_sync;
    } cpsc_port_role_t;

    // Hardware status inputs
    typedef struct packed {
        logic boost_on;
        logic some_fault_off;
        logic all_bias_fault_off;
    } cpsc_status_t;

    // Checksum update sequencing
    typedef enum logic [1:0] {
        CPSC_CK_IDLE,
        CPSC_CK_LOAD,
        CPSC_CK_ACCUM
    } cpsc_ck_state_t;

endpackage : cpsc_pkg

// ==== cpsc_port_role.sv ====
`timescale 1ns/100ps
`include "cpsc_map.svh"

module cpsc_port_role (
    // Configuration
    input  wire logic                     override_en,
    input  wire logic                     role_setting,
    input  wire logic                     int_frame_sync_bit,
    // Resolved roles
    output cpsc_pkg::cpsc_port_role_t     role
);

    wire logic ctrl_mode;

    // Override splits clocks; otherwise the role bit moves both together
    assign ctrl_mode = override_en ? role_setting : role_setting;
    assign role.bclk_out       = ctrl_mode;
    assign role.frame_sync_out      = override_en ? ~role_setting : ctrl_mode;
    assign role.auto_detect_en = ~override_en;
    // Internal frame sync only means something in controller mode
    assign role.use_int_frame_sync  = ctrl_mode & int_frame_sync_bit;

endmodule : cpsc_port_role

// ==== cpsc_regs.sv ====
`timescale 1ns/100ps
`include "cpsc_map.svh"
// Summary of operation
// - Status bit 2 shows boost converter enabled, read-only.
// - Status bit 1 set when some record channel powered down by input fault.
// - Status bit 0 set when all record channels powered down by bias fault.
// - Checksum register reads running checksum; a write loads the byte.
// - Checksum updates on every write to any other register, any page.
// - Page-select at offset 0x0 picks active page 0 to 255.
// - Volume-lock bit blocks volume changes while record channels are powered.
// - Biquad live-update bit allows coefficient changes during operation.
// - Primary override disables auto-detect; role bit splits bit clock and frame sync.
// - Secondary override behaves the same for the secondary port.
// - Primary controller mode with internal frame-sync bit uses internal frame sync.
// - Secondary controller mode with internal frame-sync bit uses internal frame sync.

module cpsc_regs (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     resetn,
    // Register access
    input  cpsc_pkg::cpsc_req_t           req,
    output logic [7:0]                    rdata_q,
    output logic                          rvalid_q,
    // Device state
    input  cpsc_pkg::cpsc_status_t        status,
    input  wire logic                     rec_powered,
    input  wire logic                     primary_role_setting,
    input  wire logic                     secondary_role_setting,
    // Live-change gates
    input  wire logic                     volume_change_req,
    input  wire logic                     biquad_change_req,
    output logic                          volume_change_ok_q,
    output logic                          biquad_change_ok_q,
    // Serial port roles
    output cpsc_pkg::cpsc_port_role_t     primary_serial_port_q,
    output cpsc_pkg::cpsc_port_role_t     secondary_serial_port_q,
    // Active page
    output logic [7:0]                    page_q
);

    logic [7:0] dsp_ctrl_q;
    logic [7:0] dsp_ctrl_d;
    logic [7:0] clk_role_q;
    logic [7:0] clk_role_d;
    logic [7:0] checksum_q;
    logic [7:0] checksum_d;
    logic [7:0] page_d;
    logic [7:0] status_one;
    logic [7:0] rdata_d;

    cpsc_pkg::cpsc_port_role_t pri_role;
    cpsc_pkg::cpsc_port_role_t sec_role;

    // Address match on the active page
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off,
                                 input logic [7:0] pg, input logic [7:0] want);
        hit = (addr == off) && (pg == want);
    endfunction : hit

    wire logic wr_page;
    wire logic wr_dsp;
    wire logic wr_clk;
    wire logic wr_cksum;
    wire logic on_page0;

    // Page register is visible on every page, as it must be to leave one
    assign on_page0 = (page_q == 8'h00);
    assign wr_page  = req.wr && (req.addr == `CPSC_OFF_PAGE);
    assign wr_dsp   = req.wr && hit(req.addr, `CPSC_OFF_DSP_CTRL, page_q, `CPSC_PAGE_CFG);
    assign wr_clk   = req.wr && hit(req.addr, `CPSC_OFF_CLK_ROLE, page_q, `CPSC_PAGE_CFG);
    assign wr_cksum = req.wr && on_page0 && (req.addr == `CPSC_OFF_CHECKSUM);

    // Status bits straight from hardware, upper bits not covered here read zero
    assign status_one = {5'h00, status.boost_on,
                         status.some_fault_off,
                         status.all_bias_fault_off};

    // Next values; reserved bits are masked so they never change
    assign page_d     = wr_page ? req.wdata : page_q;
    assign dsp_ctrl_d = wr_dsp ? (req.wdata & `CPSC_WMASK_DSP_CTRL) : dsp_ctrl_q;
    assign clk_role_d = wr_clk ? (req.wdata & `CPSC_WMASK_CLK_ROLE) : clk_role_q;

    // Load on own write, else accumulate addr plus data of any write
    assign checksum_d = wr_cksum ? req.wdata :
                        req.wr   ? 8'(checksum_q + req.addr + req.wdata) :
                                   checksum_q;

    wire logic rd_page;
    wire logic rd_dsp;
    wire logic rd_clk;
    wire logic rd_sts;
    wire logic rd_cksum;

    // Read selects; the page register answers on every page
    assign rd_page  = (req.addr == `CPSC_OFF_PAGE);
    assign rd_dsp   = hit(req.addr, `CPSC_OFF_DSP_CTRL, page_q, `CPSC_PAGE_CFG);
    assign rd_clk   = hit(req.addr, `CPSC_OFF_CLK_ROLE, page_q, `CPSC_PAGE_CFG);
    assign rd_sts   = on_page0 && (req.addr == `CPSC_OFF_STATUS_ONE);
    assign rd_cksum = on_page0 && (req.addr == `CPSC_OFF_CHECKSUM);

    // Read mux; unmapped locations read zero
    assign rdata_d = rd_page  ? page_q :
                     rd_dsp   ? dsp_ctrl_q :
                     rd_clk   ? clk_role_q :
                     rd_sts   ? status_one :
                     rd_cksum ? checksum_q : 8'h00;

    // Port role decode shared between both ports
    cpsc_port_role u_pri (
        .override_en   (clk_role_q[`CPSC_BIT_PRI_OVR]),
        .role_setting  (primary_role_setting),
        .int_frame_sync_bit (clk_role_q[`CPSC_BIT_PRI_FS]),
        .role          (pri_role)
    );

    cpsc_port_role u_sec (
        .override_en   (clk_role_q[`CPSC_BIT_SEC_OVR]),
        .role_setting  (secondary_role_setting),
        .int_frame_sync_bit (clk_role_q[`CPSC_BIT_SEC_FS]),
        .role          (sec_role)
    );

    // Control registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            page_q     <= `CPSC_RST_PAGE;
            dsp_ctrl_q <= `CPSC_RST_DSP_CTRL;
            clk_role_q <= `CPSC_RST_CLK_ROLE;
            checksum_q <= `CPSC_RST_CHECKSUM;
        end else begin
            page_q     <= page_d;
            dsp_ctrl_q <= dsp_ctrl_d;
            clk_role_q <= clk_role_d;
            checksum_q <= checksum_d;
        end
    end

    // Read data, registered one cycle after the request
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= req.rd ? rdata_d : rdata_q;
            rvalid_q <= req.rd;
        end
    end

    // Live-change gates; volume lock only bites while recording is powered
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            volume_change_ok_q <= 1'b0;
            biquad_change_ok_q <= 1'b0;
        end else begin
            volume_change_ok_q <= volume_change_req &&
                !(dsp_ctrl_q[`CPSC_BIT_VOL_LOCK] && rec_powered);
            biquad_change_ok_q <= biquad_change_req &&
                (dsp_ctrl_q[`CPSC_BIT_BIQUAD] || !rec_powered);
        end
    end

    // Registered role outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            primary_serial_port_q   <= '0;
            secondary_serial_port_q <= '0;
        end else begin
            primary_serial_port_q   <= pri_role;
            secondary_serial_port_q <= sec_role;
        end
    end

endmodule : cpsc_regs

// ==== cpsc_regs_assertions.sv ====
`timescale 1ns/100ps
`include "cpsc_map.svh"
module cpsc_chk (
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 resetn,
    // Bus and page
    input cpsc_pkg::cpsc_req_t       req,
    input wire logic [7:0]           rdata_q,
    input wire logic                 rvalid_q,
    input wire logic [7:0]           page_q,
    // Device state and outputs
    input cpsc_pkg::cpsc_status_t    status,
    input wire logic                 rec_powered,
    input wire logic                 primary_role_setting,
    input wire logic                 volume_change_req,
    input wire logic                 biquad_change_req,
    input wire logic                 volume_change_ok_q,
    input wire logic                 biquad_change_ok_q,
    input cpsc_pkg::cpsc_port_role_t primary_serial_port_q
);
    logic [7:0] dsp_q;
    logic [7:0] role_q;
    logic [1:0] live_q;
    wire        p1_wr = req.wr && page_q == `CPSC_PAGE_CFG;
    wire        p0 = page_q == 8'h00;
    wire        ovr = role_q[7];
    wire        set = primary_role_setting;
    // Shadow config so the gates are judged from ports alone
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dsp_q <= 8'h00;
            role_q <= 8'h00;
            live_q <= 2'h0;
        end else begin
            live_q <= {live_q[0], 1'b1};
            if (p1_wr && req.addr == 8'h03) dsp_q <= req.wdata;
            if (p1_wr && req.addr == 8'h0D) role_q <= req.wdata;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_read_answer: assert property (live_q[0] |-> rvalid_q == $past(req.rd))
        else $error("read answer pulse wrong");
    a_status_bits: assert property (req.rd && p0 && req.addr == 8'h7A
        |=> rdata_q == {5'h00, $past(status)}) else $error("status byte wrong");
    a_page_load: assert property (req.wr && req.addr == 8'h00
        |=> page_q == $past(req.wdata)) else $error("page not loaded");
    a_cksum_load: assert property (req.wr && p0 && req.addr == 8'h7E ##1 !req.wr ##1
        req.rd && p0 && req.addr == 8'h7E |=> rdata_q == $past(req.wdata, 3))
        else $error("checksum not loaded");
    a_volume_gate: assert property (live_q[1] |-> volume_change_ok_q ==
        $past(volume_change_req && !(dsp_q[1] && rec_powered))) else $error("volume gate");
    a_biquad_gate: assert property (live_q[1] |-> biquad_change_ok_q ==
        $past(biquad_change_req && (dsp_q[0] || !rec_powered))) else $error("biquad gate");
    a_reserved_zero: assert property (req.rd && p1_wr == 0 && page_q == 8'h01
        && req.addr == 8'h03 |=> rdata_q[7:2] == 6'h00) else $error("reserved bits set");
    a_primary_role: assert property (live_q[1] && $stable(set) && $stable(role_q)
        |-> primary_serial_port_q == {set, ovr ? !set : set, !ovr, set & role_q[2]})
        else $error("primary role wrong");
    c_lock: cover property (volume_change_req && dsp_q[1] && rec_powered);
    c_live_bq: cover property (biquad_change_req && dsp_q[0] && rec_powered);
    c_override: cover property (ovr && set);
endmodule : cpsc_chk
bind cpsc_regs cpsc_chk CHK (.clk, .resetn, .req, .rdata_q, .rvalid_q, .page_q, .status,
    .rec_powered, .primary_role_setting, .volume_change_req, .biquad_change_req,
    .volume_change_ok_q, .biquad_change_ok_q, .primary_serial_port_q);

// ==== cpsc_host.sv ====
`timescale 1ns/100ps
module cpsc_host (
    // Clock and read data
    input wire logic           clk,
    input wire logic [7:0]     rdata_q,
    // Request to the device
    output cpsc_pkg::cpsc_req_t req
);
    initial req = '0;
    // One access, strobe held for exactly one sampling edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(negedge clk);
        req <= '{w, !w, a, d};
        @(negedge clk);
        req <= '0;
        q = rdata_q;
    endtask : acc
endmodule : cpsc_host

// ==== codec_paged_status_config_regs_tb.sv ====
`timescale 1ns/100ps
module codec_paged_status_config_regs_tb;
    logic clk = 0, resetn = 0, pw, sw, vr, br, rp, rv, vo, bo;
    logic [7:0] rd, pg;
    logic [31:0] seed = 32'hba8d_280f;
    cpsc_pkg::cpsc_req_t req;
    cpsc_pkg::cpsc_status_t st;
    cpsc_pkg::cpsc_port_role_t pp, sp;
    int errors = 0, n_compared = 0, ck = 0, pgm = 0, dsp = 0, rol = 0;
    always #5 clk = ~clk;
    cpsc_host HOST (.clk(clk), .rdata_q(rd), .req(req));
    cpsc_regs DUT (.clk(clk), .resetn(resetn), .req(req), .rdata_q(rd), .rvalid_q(rv),
        .status(st), .rec_powered(rp), .primary_role_setting(pw), .secondary_role_setting(sw),
        .volume_change_req(vr), .biquad_change_req(br), .volume_change_ok_q(vo),
        .biquad_change_ok_q(bo), .primary_serial_port_q(pp), .secondary_serial_port_q(sp),
        .page_q(pg));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    function automatic logic [7:0] role(input logic o, input logic s, input logic b);
        return {4'h0, s, o ? !s : s, !o, s & b};
    endfunction : role
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    // Model keeps page, checksum and masked config alongside each write
    task automatic wr(input int a, input int d);
        logic [7:0] q;
        HOST.acc(1, a[7:0], d[7:0], q);
        if (a == 8'h7E && pgm == 0) ck = d;
        else ck = (ck + a + d) % 256;
        if (pgm == 1 && a == 3) dsp = d & 8'h03;
        if (pgm == 1 && a == 8'h0D) rol = d & 8'hC6;
        if (a == 0) pgm = d;
        cmp(pg, pgm[7:0]);
    endtask : wr
    task automatic rdc(input int a, input int exp);
        logic [7:0] q;
        HOST.acc(0, a[7:0], 8'h00, q);
        cmp(8'(rv), 8'h01);
        cmp(q, exp[7:0]);
    endtask : rdc
    task automatic print_verdict();
        if (errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    // Hang guard
    initial begin
        #200_000;
        errors++;
        print_verdict();
    end
    initial begin
        {pw, sw, vr, br, rp} = '0;
        st = '0;
        repeat (2) @(posedge clk);
        @(negedge clk) resetn = 1;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk) st = i[2:0];
            rdc(8'h7A, i);
        end
        wr(8'h7E, 8'h5A);
        rdc(8'h7E, ck);
        // Unmapped probe on page 0; page-1 gaps stay untouched
        wr(8'h33, 8'h12);
        rdc(8'h7E, ck);
        wr(0, 1);
        rdc(0, 1);
        wr(3, 8'hFF);
        rdc(3, dsp);
        wr(8'h0D, 8'hFF);
        rdc(8'h0D, rol);
        repeat (40) begin
            seed = xs(seed);
            // Random lock; high-rate multi-channel set-ups would set it
            wr(3, seed[1:0]);
            wr(8'h0D, seed[15:8] & 8'hC6);
            @(negedge clk) {pw, sw, vr, br, rp} = seed[20:16];
            repeat (2) @(negedge clk);
            cmp(8'(vo), 8'(vr && !(dsp[1] && rp)));
            cmp(8'(bo), 8'(br && (dsp[0] || !rp)));
            cmp(8'(pp), role(rol[7], pw, rol[2]));
            cmp(8'(sp), role(rol[6], sw, rol[1]));
        end
        wr(0, 0);
        rdc(8'h7E, ck);
        print_verdict();
    end
endmodule : codec_paged_status_config_regs_tb
